// ==== sam_service_top.sv ====
/*
  service request aggregation, external interrupt and cpu page window,
  reached over an ahb-lite slave with 32-bit data.
  assumes unit event and enable vectors come from logic on core_clk_in.
*/
`timescale 1ns/1ns
`include "sam_regs.svh"

// Functional notes
// - status bit 0 is set when any frame-bus event meets its enable
// - status bit 1 is set when any cell transmit event meets its enable
// - status bit 2 is set when any cell receive event meets its enable
// - status bit 3 is set when any port mux event meets its enable
// - status bit 4 is set when any clock recovery event meets its enable
// - interrupt output high while any service bit and its enable are high
// - status bit 7 is the or of service bits four to zero
// - window bit 0 drives external address line 14
// - window bit 1 drives line 15, or bank select in 32k mode
// - window bit 2 drives line 16, or bank select in 64k mode
// - window bit 3 drives line 17, or bank select in 128k mode
// - window bit 4 drives bank select only in 256k mode
// - main control bits 0 to 4 enable the five unit interrupts
// - two-bit size field picks 32k, 64k, 128k or 256k memory
module sam_service_top #(
  parameter int EVW = 16
) (
  // clock, reset, enable
  input  wire logic             core_clk_in,
  input  wire logic             srst_in,
  input  wire logic             clk_en_in,
  // ahb-lite slave
  input  wire logic             hsel_in,
  input  wire logic [11:0]      haddr_in,
  input  wire logic [1:0]       htrans_in,
  input  wire logic             hwrite_in,
  input  wire logic [2:0]       hsize_in,
  input  wire logic [31:0]      hwdata_in,
  input  wire logic             hready_in,
  output logic      [31:0]      hrdata_out,
  output logic                  hreadyout_out,
  output logic                  hresp_out,
  // unit event and enable vectors
  input  wire logic [EVW-1:0]   frame_bus_event_in,
  input  wire logic [EVW-1:0]   frame_bus_enable_in,
  input  wire logic [EVW-1:0]   cell_tx_event_in,
  input  wire logic [EVW-1:0]   cell_tx_enable_in,
  input  wire logic [EVW-1:0]   cell_rx_event_in,
  input  wire logic [EVW-1:0]   cell_rx_enable_in,
  input  wire logic [EVW-1:0]   cell_mux_event_in,
  input  wire logic [EVW-1:0]   cell_mux_enable_in,
  input  wire logic [EVW-1:0]   timing_event_in,
  input  wire logic [EVW-1:0]   timing_enable_in,
  // interrupt and memory window
  output logic                  irq_out,
  output logic                  service_out,
  output logic      [3:0]       mem_addr_hi_out,
  output logic                  bank_select_out
);
  localparam int NU = `SAM_NUM_UNITS;

  function automatic logic any_pair(input logic [EVW-1:0] ev, input logic [EVW-1:0] en);
    any_pair = |(ev & en);
  endfunction

  // per-unit request vector
  logic [NU-1:0]  unit_request;
  logic [NU-1:0]  irq_enable;
  logic [15:0]    main_control;
  logic [15:0]    page_window;
  logic [15:0]    mem_config;
  logic [NU-1:0]  service;
  logic           irq;
  logic [NU-1:0]  next_service;
  logic           next_irq;

  always_comb begin
    unit_request[0] = any_pair(frame_bus_event_in, frame_bus_enable_in);
    unit_request[1] = any_pair(cell_tx_event_in, cell_tx_enable_in);
    unit_request[2] = any_pair(cell_rx_event_in, cell_rx_enable_in);
    unit_request[3] = any_pair(cell_mux_event_in, cell_mux_enable_in);
    unit_request[4] = any_pair(timing_event_in, timing_enable_in);
  end

  assign irq_enable = main_control[NU-1:0];

  always_comb begin
    next_service = unit_request;
    next_irq     = |(unit_request & irq_enable);
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      service <= '0;
      irq     <= 1'b0;
    end else if (clk_en_in) begin
      service <= next_service;
      irq     <= next_irq;
    end
  end

  assign irq_out     = irq;
  assign service_out = |service;

  // ahb-lite slave: zero wait states while clk_en_in is high, always okay
  logic                 ph_write;
  logic                 ph_read;
  logic [11:0]          ph_addr;
  sam_pkg::sam_phase_t  phase;
  logic                 next_ph_write;
  logic                 next_ph_read;
  logic [11:0]          next_ph_addr;
  sam_pkg::sam_phase_t  next_phase;
  logic [31:0]          rdata;
  logic [31:0]          next_rdata;
  logic [15:0]          next_main_control;
  logic [15:0]          next_page_window;
  logic [15:0]          next_mem_config;
  logic                 accept;

  assign accept = hsel_in && hready_in && htrans_in[1];

  always_comb begin
    next_ph_write = accept && hwrite_in;
    next_ph_read  = accept && !hwrite_in;
    next_ph_addr  = accept ? haddr_in : ph_addr;
    next_phase    = accept ? sam_pkg::SAM_PH_DATA : sam_pkg::SAM_PH_IDLE;
    next_rdata    = rdata;
    if (next_ph_read) begin
      if (haddr_in == `SAM_OFS_MAIN_CONTROL) begin
        next_rdata = {16'h0000, main_control};
      end else if (haddr_in == `SAM_OFS_SERVICE_STATUS) begin
        next_rdata = {24'h000000, |service, 2'b00, service};
      end else if (haddr_in == `SAM_OFS_PAGE_WINDOW) begin
        next_rdata = {16'h0000, page_window};
      end else if (haddr_in == `SAM_OFS_MEM_CONFIG) begin
        next_rdata = {16'h0000, mem_config};
      end else begin
        next_rdata = 32'h00000000;
      end
    end
  end

  always_comb begin
    next_main_control = main_control;
    next_page_window  = page_window;
    next_mem_config   = mem_config;
    if (ph_write) begin
      if (ph_addr == `SAM_OFS_MAIN_CONTROL) begin
        next_main_control = hwdata_in[15:0];
      end else if (ph_addr == `SAM_OFS_PAGE_WINDOW) begin
        next_page_window = hwdata_in[15:0];
      end else if (ph_addr == `SAM_OFS_MEM_CONFIG) begin
        next_mem_config = hwdata_in[15:0];
      end
      // status writes are dropped
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ph_write     <= 1'b0;
      ph_read      <= 1'b0;
      ph_addr      <= 12'h000;
      phase        <= sam_pkg::SAM_PH_IDLE;
      rdata        <= 32'h00000000;
      main_control <= `SAM_RST_MAIN_CONTROL;
      page_window  <= `SAM_RST_PAGE_WINDOW;
      mem_config   <= `SAM_RST_MEM_CONFIG;
    end else if (clk_en_in) begin
      ph_write     <= next_ph_write;
      ph_read      <= next_ph_read;
      ph_addr      <= next_ph_addr;
      phase        <= next_phase;
      rdata        <= next_rdata;
      main_control <= next_main_control;
      page_window  <= next_page_window;
      mem_config   <= next_mem_config;
    end
  end

  assign hrdata_out    = rdata;
  assign hreadyout_out = clk_en_in || phase == sam_pkg::SAM_PH_IDLE;
  assign hresp_out     = 1'b0;

  sam_window_map u_map (
    .core_clk_in     (core_clk_in),
    .srst_in         (srst_in),
    .clk_en_in       (clk_en_in),
    .window_in       (page_window[`SAM_WINDOW_BITS-1:0]),
    .size_in         (sam_pkg::sam_size_t'(mem_config[`SAM_SIZE_BITS-1:0])),
    .mem_addr_hi_out (mem_addr_hi_out),
    .bank_select_out (bank_select_out)
  );

  a_irq_follows : assert property (@(posedge core_clk_in) disable iff (srst_in)
    clk_en_in |=> irq_out == |($past(unit_request) & $past(irq_enable)))
    else $error("interrupt does not follow enabled service");
  a_irq_masked : assert property (@(posedge core_clk_in) disable iff (srst_in)
    clk_en_in && irq_enable == 5'h00 |=> !irq_out)
    else $error("interrupt with all enables clear");
  a_frame_req : assert property (@(posedge core_clk_in) disable iff (srst_in)
    clk_en_in |=> service[0] == $past(|(frame_bus_event_in & frame_bus_enable_in)))
    else $error("frame-bus service bit wrong");
  a_tx_req : assert property (@(posedge core_clk_in) disable iff (srst_in)
    clk_en_in |=> service[1] == $past(|(cell_tx_event_in & cell_tx_enable_in)))
    else $error("transmit service bit wrong");
  a_rx_req : assert property (@(posedge core_clk_in) disable iff (srst_in)
    clk_en_in |=> service[2] == $past(|(cell_rx_event_in & cell_rx_enable_in)))
    else $error("receive service bit wrong");
  a_mux_req : assert property (@(posedge core_clk_in) disable iff (srst_in)
    clk_en_in |=> service[3] == $past(|(cell_mux_event_in & cell_mux_enable_in)))
    else $error("mux service bit wrong");
  a_timing_req : assert property (@(posedge core_clk_in) disable iff (srst_in)
    clk_en_in |=> service[4] == $past(|(timing_event_in & timing_enable_in)))
    else $error("timing service bit wrong");
  a_service_sum : assert property (@(posedge core_clk_in) disable iff (srst_in)
    service_out == (service != 5'h00))
    else $error("summary bit wrong");
  a_status_read : assert property (@(posedge core_clk_in) disable iff (srst_in)
    clk_en_in && accept && !hwrite_in && haddr_in == `SAM_OFS_SERVICE_STATUS
    |=> hrdata_out[31:8] == 24'h000000 && hrdata_out[4:0] == $past(service))
    else $error("status read wrong");
  a_status_nowrite : assert property (@(posedge core_clk_in) disable iff (srst_in)
    clk_en_in && ph_write && ph_addr == `SAM_OFS_SERVICE_STATUS
    |=> main_control == $past(main_control) && page_window == $past(page_window))
    else $error("status write changed a register");

  c_irq_raised : cover property (@(posedge core_clk_in) disable iff (srst_in) $rose(irq_out));
  c_window_wr  : cover property (@(posedge core_clk_in) disable iff (srst_in)
    ph_write && ph_addr == `SAM_OFS_PAGE_WINDOW);
  c_all_units  : cover property (@(posedge core_clk_in) disable iff (srst_in) &service);
endmodule

// ==== sam_regs.svh ====
/*
  register offsets, field positions and reset values of the service
  aggregation and memory window block.
  assumes it is included by bare name inside the modules and the testbench.
*/
`ifndef SAM_REGS_SVH
`define SAM_REGS_SVH

// status index 2 is a word offset: byte address is four times the index
`define SAM_IDX_MAIN_CONTROL   0
`define SAM_IDX_SERVICE_STATUS 2
`define SAM_OFS_MAIN_CONTROL   12'h000
`define SAM_OFS_SERVICE_STATUS 12'h008
`define SAM_OFS_PAGE_WINDOW    12'h004
`define SAM_OFS_MEM_CONFIG     12'h00c

`define SAM_NUM_UNITS          5
`define SAM_SERVICE_BIT        7
`define SAM_WINDOW_BITS        5
`define SAM_SIZE_BITS          2
`define SAM_RST_MAIN_CONTROL   16'h0000
`define SAM_RST_PAGE_WINDOW    16'h0000
`define SAM_RST_MEM_CONFIG     16'h0000

`endif

// ==== sam_pkg.sv ====
/*
  types shared by the service aggregation block.
  assumes sam_regs.svh is on the include path.
*/
package sam_pkg;
  typedef enum logic [1:0] {
    SAM_SIZE_32K  = 2'b00,
    SAM_SIZE_64K  = 2'b01,
    SAM_SIZE_128K = 2'b10,
    SAM_SIZE_256K = 2'b11
  } sam_size_t;

  typedef enum logic [0:0] {
    SAM_PH_IDLE = 1'b0,
    SAM_PH_DATA = 1'b1
  } sam_phase_t;
endpackage

// ==== sam_window_map.sv ====
/*
  maps the five page window bits onto the upper external memory address
  lines and the bank select according to the memory size field.
  assumes a registered window and size setting from the same clock domain.
*/
`timescale 1ns/1ns
`include "sam_regs.svh"

module sam_window_map (
  // clock, reset, enable
  input  wire logic                          core_clk_in,
  input  wire logic                          srst_in,
  input  wire logic                          clk_en_in,
  // settings
  input  wire logic [`SAM_WINDOW_BITS-1:0]   window_in,
  input  wire sam_pkg::sam_size_t            size_in,
  // external address lines 17:14 and bank select
  output logic      [3:0]                    mem_addr_hi_out,
  output logic                               bank_select_out
);
  logic [3:0] next_mem_addr_hi;
  logic       next_bank_select;
  logic [3:0] mem_addr_hi;
  logic       bank_select;

  always_comb begin
    next_mem_addr_hi    = 4'h0;
    next_mem_addr_hi[0] = window_in[0];
    next_bank_select    = 1'b0;
    case (size_in)
      sam_pkg::SAM_SIZE_32K: begin
        next_bank_select = window_in[1];
      end
      sam_pkg::SAM_SIZE_64K: begin
        next_mem_addr_hi[1] = window_in[1];
        next_bank_select    = window_in[2];
      end
      sam_pkg::SAM_SIZE_128K: begin
        next_mem_addr_hi[2:1] = window_in[2:1];
        next_bank_select      = window_in[3];
      end
      default: begin
        next_mem_addr_hi[3:1] = window_in[3:1];
        next_bank_select      = window_in[4];
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      mem_addr_hi <= 4'h0;
      bank_select <= 1'b0;
    end else if (clk_en_in) begin
      mem_addr_hi <= next_mem_addr_hi;
      bank_select <= next_bank_select;
    end
  end

  assign mem_addr_hi_out = mem_addr_hi;
  assign bank_select_out = bank_select;

  a_map_line14 : assert property (@(posedge core_clk_in) disable iff (srst_in)
    clk_en_in |=> mem_addr_hi_out[0] == $past(window_in[0]))
    else $error("address line 14 does not follow window bit 0");
  a_map_bank256 : assert property (@(posedge core_clk_in) disable iff (srst_in)
    clk_en_in && size_in == sam_pkg::SAM_SIZE_256K
    |=> bank_select_out == $past(window_in[4]))
    else $error("bank select does not follow window bit 4 in 256k mode");
  a_map_bank32 : assert property (@(posedge core_clk_in) disable iff (srst_in)
    clk_en_in && size_in == sam_pkg::SAM_SIZE_32K
    |=> bank_select_out == $past(window_in[1]) && mem_addr_hi_out[3:1] == 3'h0)
    else $error("32k mode mapping wrong");
endmodule

// ==== sam_service_top_tb.sv ====
/*
  self-checking testbench of the service aggregation and memory window block.
  assumes sam_regs.svh and sam_pkg are compiled first; one ahb-lite slave.
*/
`timescale 1ns/1ns
`include "sam_regs.svh"

`define CHK(nm, ex, got) begin \
  checks_done++; \
  if ((got) !== (ex)) begin \
    err_count++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); \
  end \
end

module sam_service_top_tb;
  localparam int EVW = 16;
  // clock, reset and bus master
  logic            core_clk_in = 1'b0;
  logic            srst_in     = 1'b1;
  logic            clk_en_in   = 1'b1;
  logic            hsel_in     = 1'b0;
  logic [11:0]     haddr_in    = 12'h000;
  logic [1:0]      htrans_in   = 2'b00;
  logic            hwrite_in   = 1'b0;
  logic [2:0]      hsize_in    = 3'b010;
  logic [31:0]     hwdata_in   = 32'h0000_0000;
  // design outputs
  logic [31:0]     hrdata_out;
  logic            hreadyout_out;
  logic            hresp_out;
  logic            irq_out;
  logic            service_out;
  logic [3:0]      mem_addr_hi_out;
  logic            bank_select_out;
  // unit event and enable vectors
  logic [EVW-1:0]  ev [5];
  logic [EVW-1:0]  en [5];
  int              err_count   = 0;
  int              checks_done = 0;

  always #4 core_clk_in = ~core_clk_in;

  sam_service_top #(.EVW(EVW)) sam_service_top_i (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .clk_en_in(clk_en_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .frame_bus_event_in(ev[0]), .frame_bus_enable_in(en[0]),
    .cell_tx_event_in(ev[1]), .cell_tx_enable_in(en[1]),
    .cell_rx_event_in(ev[2]), .cell_rx_enable_in(en[2]),
    .cell_mux_event_in(ev[3]), .cell_mux_enable_in(en[3]),
    .timing_event_in(ev[4]), .timing_enable_in(en[4]),
    .irq_out(irq_out), .service_out(service_out),
    .mem_addr_hi_out(mem_addr_hi_out), .bank_select_out(bank_select_out)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // waits for hready high at a rising edge, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("[ERR] hready expected 1 seen timeout");
      wrap_up();
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk_in);
    hsel_in   <= 1'b1;
    htrans_in <= 2'b10;
    haddr_in  <= a;
    hwrite_in <= wr;
    wait_ready();
    hsel_in   <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= d;
    wait_ready();
    q = hrdata_out;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    `CHK($sformatf("read %h", a), e, q)
    `CHK("hresp", 1'b0, hresp_out)
  endtask

  // frozen clock enable holds service state until released
  task automatic chk_freeze();
    @(posedge core_clk_in);
    clk_en_in <= 1'b0;
    ev[0]     <= 16'h0001;
    en[0]     <= 16'h0001;
    settle();
    `CHK("frozen service", 1'b0, service_out)
    @(posedge core_clk_in);
    clk_en_in <= 1'b1;
    settle();
    `CHK("service", 1'b1, service_out)
    @(posedge core_clk_in);
    ev[0] <= 16'h0000;
    en[0] <= 16'h0000;
    settle();
    `CHK("service", 1'b0, service_out)
  endtask

  task automatic settle();
    repeat (3) @(posedge core_clk_in);
  endtask

  task automatic chk_reset();
    rd_chk(`SAM_OFS_MAIN_CONTROL, 32'h0000_0000);
    rd_chk(`SAM_OFS_PAGE_WINDOW, 32'h0000_0000);
    rd_chk(`SAM_OFS_MEM_CONFIG, 32'h0000_0000);
    rd_chk(`SAM_OFS_SERVICE_STATUS, 32'h0000_0000);
    `CHK("irq", 1'b0, irq_out)
    `CHK("addr_hi", 4'h0, mem_addr_hi_out)
  endtask

  // each unit: mismatched bits give no request, a matching pair does
  task automatic chk_service();
    for (int u = 0; u < 5; u++) begin
      @(posedge core_clk_in);
      ev[u] <= 16'h8001;
      en[u] <= 16'h0100;
      settle();
      rd_chk(`SAM_OFS_SERVICE_STATUS, 32'h0000_0000);
      @(posedge core_clk_in);
      en[u] <= 16'h8000;
      settle();
      rd_chk(`SAM_OFS_SERVICE_STATUS, 32'h80 | (32'h1 << u));
      `CHK("service", 1'b1, service_out)
      @(posedge core_clk_in);
      ev[u] <= 16'h0000;
      settle();
      rd_chk(`SAM_OFS_SERVICE_STATUS, 32'h0000_0000);
    end
  endtask

  // irq needs both the request and its own enable; status ignores writes
  task automatic chk_irq();
    for (int u = 0; u < 5; u++) begin
      @(posedge core_clk_in);
      ev[u] <= 16'h0004;
      en[u] <= 16'h0004;
      wr(`SAM_OFS_MAIN_CONTROL, 32'h1f & ~(32'h1 << u));
      settle();
      `CHK("irq", 1'b0, irq_out)
      wr(`SAM_OFS_MAIN_CONTROL, 32'h1 << u);
      settle();
      `CHK("irq", 1'b1, irq_out)
      rd_chk(`SAM_OFS_MAIN_CONTROL, 32'h1 << u);
      wr(`SAM_OFS_SERVICE_STATUS, 32'h0000_0000);
      rd_chk(`SAM_OFS_SERVICE_STATUS, 32'h80 | (32'h1 << u));
      @(posedge core_clk_in);
      ev[u] <= 16'h0000;
      en[u] <= 16'h0000;
      settle();
      `CHK("irq", 1'b0, irq_out)
    end
    wr(12'h010, 32'hffff_ffff);
    rd_chk(12'h010, 32'h0000_0000);
  endtask

  // every size mode with several window patterns
  task automatic chk_window();
    logic [4:0] pats [3];
    logic [4:0] w;
    logic [3:0] msk;
    pats = '{5'h15, 5'h0a, 5'h1f};
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 3; k++) begin
        w = pats[k];
        msk = 4'hf >> (3 - m);
        wr(`SAM_OFS_MEM_CONFIG, 32'(m));
        wr(`SAM_OFS_PAGE_WINDOW, {27'h0, w});
        settle();
        `CHK("addr_hi", w[3:0] & msk, mem_addr_hi_out)
        `CHK("bank", w[m+1], bank_select_out)
        rd_chk(`SAM_OFS_PAGE_WINDOW, {27'h0, w});
      end
    end
  endtask

  initial begin
    for (int i = 0; i < 5; i++) begin
      ev[i] = '0;
      en[i] = '0;
    end
    repeat (4) @(posedge core_clk_in);
    srst_in <= 1'b0;
    chk_reset();
    chk_service();
    chk_irq();
    chk_window();
    chk_freeze();
    wrap_up();
  end
endmodule
